// >>> src/elwt_top.sv
/*
 * External level/window trigger with two TTL trigger lines and an
 * AHB-Lite register slave. One clock; samples are taken on an enable
 * pulse from a software-set divider. Analog samples and TTL lines are
 * assumed synchronous to sys_clk_in; start_in arms the engine.
 */
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "elwt_params.svh"

module elwt_top #(
	parameter int ADC_W = 14,
	parameter logic [31:0] LINE0_AVAIL = `ELWT_RST_AVAIL,
	parameter logic [31:0] LINE1_AVAIL = `ELWT_RST_AVAIL
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// Trigger inputs
	input wire logic signed [ADC_W-1:0] ext_sample_in,
	input wire logic [1:0] ttl_line_in,
	// Acquisition control
	input wire logic start_in,
	// Trigger outputs
	output logic trigger_out,
	output logic ana_gate_out,
	output logic [1:0] line_gate_out,
	output logic armed_out
);

	localparam logic signed [ADC_W-1:0] CODE_MAX = ADC_W'(`ELWT_FULL_CODE);

	elwt_pkg::elwt_cfg_s cfg_q;
	elwt_pkg::elwt_det_s det_q;
	elwt_pkg::elwt_state_e state_q;
	logic [31:0] div_cnt_q;
	logic sample_en;
	logic signed [ADC_W-1:0] upper_code_q;
	logic signed [ADC_W-1:0] lower_code_q;
	logic signed [ADC_W-1:0] sample_q;
	logic [1:0] ttl_q;
	logic [1:0] ttl_prev_q;
	logic ana_gate_prev_q;
	logic [1:0] line_gate_prev_q;
	logic first_q;
	logic eval_q;
	logic any_hit;
	logic and_hit;
	logic fire;

	// Millivolt to sample code, clamped to the converter range
	function automatic logic signed [ADC_W-1:0] mv_to_code(input logic signed [31:0] mv);
		logic signed [63:0] prod;
		logic signed [63:0] quot;
		prod = 64'(mv) * 64'(`ELWT_FULL_CODE);
		quot = prod / 64'(`ELWT_FULL_MV);
		if (quot > 64'(`ELWT_FULL_CODE)) begin
			mv_to_code = CODE_MAX;
		end else if (quot < -64'(`ELWT_FULL_CODE)) begin
			mv_to_code = -CODE_MAX;
		end else begin
			mv_to_code = quot[ADC_W-1:0];
		end
	endfunction

	// Bus slave state
	logic acc_q;
	logic acc_wr_q;
	logic [17:0] acc_idx_q;
	logic rdy_q;
	logic [31:0] rdata_q;
	logic addr_phase;
	logic [31:0] rd_mux;
	logic [31:0] status_word;

	// Valid address phase, non-word sizes are still taken as words
	assign addr_phase = hsel_in & htrans_in[1] & hready_in;

	// Address phase capture; one wait state then completion
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			acc_q <= 1'b0;
			acc_wr_q <= 1'b0;
			acc_idx_q <= 18'h00000;
			rdy_q <= 1'b1;
		end else begin
			acc_q <= addr_phase;
			rdy_q <= ~addr_phase;
			if (addr_phase) begin
				acc_wr_q <= hwrite_in;
				acc_idx_q <= haddr_in[19:2];
			end
		end
	end

	assign hreadyout_out = rdy_q;
	assign hresp_out = 1'b0; // Always OKAY, unmapped reads give zero

	// Status word: engine state and live gates
	assign status_word = {26'h0000000, line_gate_out, ana_gate_out, state_q, armed_out};

	// Read decode
	always_comb begin
		case (acc_idx_q)
			`ELWT_IDX_OR_MASK: rd_mux = cfg_q.or_mask;
			`ELWT_IDX_AND_MASK: rd_mux = cfg_q.and_mask;
			`ELWT_IDX_LINE0_AVAIL: rd_mux = LINE0_AVAIL;
			`ELWT_IDX_LINE1_AVAIL: rd_mux = LINE1_AVAIL;
			`ELWT_IDX_ANA_MODE: rd_mux = cfg_q.ana_mode;
			`ELWT_IDX_LINE0_MODE: rd_mux = cfg_q.line0_mode;
			`ELWT_IDX_LINE1_MODE: rd_mux = cfg_q.line1_mode;
			`ELWT_IDX_STATUS: rd_mux = status_word;
			`ELWT_IDX_SAMPLE_DIV: rd_mux = cfg_q.sample_div;
			`ELWT_IDX_UPPER_LVL: rd_mux = cfg_q.upper_mv;
			`ELWT_IDX_LOWER_LVL: rd_mux = cfg_q.lower_mv;
			default: rd_mux = `ELWT_RST_WORD;
		endcase
	end

	// Read data register, loaded in the wait state
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_q <= `ELWT_RST_WORD;
		end else if (acc_q && !acc_wr_q) begin
			rdata_q <= rd_mux;
		end
	end

	assign hrdata_out = rdata_q;

	// Configuration writes, taken in the wait state from hwdata
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cfg_q <= '0;
		end else if (acc_q && acc_wr_q) begin
			case (acc_idx_q)
				`ELWT_IDX_OR_MASK: cfg_q.or_mask <= hwdata_in;
				`ELWT_IDX_AND_MASK: cfg_q.and_mask <= hwdata_in;
				`ELWT_IDX_ANA_MODE: cfg_q.ana_mode <= hwdata_in;
				`ELWT_IDX_LINE0_MODE: cfg_q.line0_mode <= hwdata_in;
				`ELWT_IDX_LINE1_MODE: cfg_q.line1_mode <= hwdata_in;
				`ELWT_IDX_SAMPLE_DIV: cfg_q.sample_div <= hwdata_in;
				`ELWT_IDX_UPPER_LVL: cfg_q.upper_mv <= hwdata_in;
				`ELWT_IDX_LOWER_LVL: cfg_q.lower_mv <= hwdata_in;
				default: cfg_q <= cfg_q;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			upper_code_q <= '0;
			lower_code_q <= '0;
		end else begin
			upper_code_q <= mv_to_code(cfg_q.upper_mv);
			lower_code_q <= mv_to_code(cfg_q.lower_mv);
		end
	end

	// Sample rate divider; a setting of zero samples every clock
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			div_cnt_q <= `ELWT_RST_WORD;
		end else if (div_cnt_q >= cfg_q.sample_div) begin
			div_cnt_q <= `ELWT_RST_WORD;
		end else begin
			div_cnt_q <= div_cnt_q + 32'h0000_0001;
		end
	end

	assign sample_en = (div_cnt_q >= cfg_q.sample_div);

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sample_q <= '0;
			ttl_q <= 2'b00;
			ttl_prev_q <= 2'b00;
			eval_q <= 1'b0;
		end else begin
			eval_q <= sample_en;
			if (sample_en) begin
				sample_q <= ext_sample_in;
				ttl_q <= ttl_line_in;
				ttl_prev_q <= ttl_q;
			end
		end
	end

	// Analog gate and sole-source hit, one clock after the sample is taken
	logic ana_cond;
	always_comb begin
		case (cfg_q.ana_mode)
			`ELWT_MODE_HIGH: ana_cond = sample_q > upper_code_q;
			`ELWT_MODE_LOW: ana_cond = sample_q < upper_code_q;
			`ELWT_MODE_INWIN: ana_cond = (sample_q > lower_code_q) && (sample_q < upper_code_q);
			`ELWT_MODE_OUTWIN: ana_cond = (sample_q > upper_code_q) || (sample_q < lower_code_q);
			default: ana_cond = 1'b0;
		endcase
	end

	// Per-line TTL detectors
	logic [1:0] line_cond;
	logic [1:0] line_edge;
	logic [31:0] line_mode [2];
	assign line_mode[0] = cfg_q.line0_mode;
	assign line_mode[1] = cfg_q.line1_mode;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_line
			always_comb begin
				line_cond[gi] = 1'b0;
				line_edge[gi] = 1'b0;
				case (line_mode[gi])
					`ELWT_MODE_RISE: line_edge[gi] = ttl_q[gi] & ~ttl_prev_q[gi];
					`ELWT_MODE_FALL: line_edge[gi] = ~ttl_q[gi] & ttl_prev_q[gi];
					`ELWT_MODE_ANY: line_edge[gi] = ttl_q[gi] ^ ttl_prev_q[gi];
					`ELWT_MODE_HIGH: line_cond[gi] = ttl_q[gi];
					`ELWT_MODE_LOW: line_cond[gi] = ~ttl_q[gi];
					// Off or unknown code excludes line
					default: line_cond[gi] = 1'b0;
				endcase
			end
		end
	endgenerate

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			det_q <= '0;
			ana_gate_prev_q <= 1'b0;
			line_gate_prev_q <= 2'b00;
		end else if (eval_q) begin
			ana_gate_prev_q <= det_q.ana_gate;
			line_gate_prev_q <= det_q.line_gate;
			det_q.ana_gate <= ana_cond;
			det_q.line_gate <= line_cond;
			// Entry, or already true at start
			det_q.ana_hit <= ana_cond & (~det_q.ana_gate | first_q);
			det_q.line_hit <= line_edge | (line_cond & (~det_q.line_gate | {2{first_q}}));
		end
	end

	// Enabled sources feed OR and AND combiners
	logic [1:0] line_or_en;
	logic [1:0] line_and_en;
	logic ana_or_en;
	logic ana_and_en;
	logic and_any;
	assign line_or_en = cfg_q.or_mask[`ELWT_MASK_LINE_LSB+1:`ELWT_MASK_LINE_LSB];
	assign line_and_en = cfg_q.and_mask[`ELWT_MASK_LINE_LSB+1:`ELWT_MASK_LINE_LSB];
	assign ana_or_en = cfg_q.or_mask[`ELWT_MASK_ANALOG-1];
	assign ana_and_en = cfg_q.and_mask[`ELWT_MASK_ANALOG-1];
	assign and_any = ana_and_en | (|line_and_en);
	assign any_hit = (ana_or_en & det_q.ana_hit) | (|(line_or_en & det_q.line_hit));
	// AND: every AND-enabled source holds its gate or just hit
	assign and_hit = and_any
		& (~ana_and_en | det_q.ana_gate)
		& (&(~line_and_en | det_q.line_gate | det_q.line_hit));

	// Results are valid the cycle after the gates update
	logic det_valid_q;
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			det_valid_q <= 1'b0;
		end else begin
			det_valid_q <= eval_q;
		end
	end

	assign fire = (state_q == elwt_pkg::ELWT_ARMED) & det_valid_q & ~first_q & (any_hit | and_hit);

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= elwt_pkg::ELWT_IDLE;
		end else begin
			case (state_q)
				elwt_pkg::ELWT_IDLE: if (start_in) begin
					state_q <= elwt_pkg::ELWT_ARMED;
				end
				elwt_pkg::ELWT_ARMED: if (fire) begin
					state_q <= elwt_pkg::ELWT_FIRED;
				end
				elwt_pkg::ELWT_FIRED: if (start_in) begin
					state_q <= elwt_pkg::ELWT_ARMED;
				end
				default: state_q <= elwt_pkg::ELWT_IDLE;
			endcase
		end
	end

	// First sample after arming counts a held level as an entry
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			first_q <= 1'b0;
		end else if (start_in && state_q != elwt_pkg::ELWT_ARMED) begin
			first_q <= 1'b1;
		end else if (eval_q) begin
			first_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			trigger_out <= 1'b0;
			ana_gate_out <= 1'b0;
			line_gate_out <= 2'b00;
			armed_out <= 1'b0;
		end else begin
			trigger_out <= fire;
			ana_gate_out <= det_q.ana_gate;
			line_gate_out <= det_q.line_gate;
			armed_out <= (state_q == elwt_pkg::ELWT_ARMED) & ~fire;
		end
	end

endmodule
`default_nettype wire

// >>> inc/elwt_params.svh
/*
 * Constants for the external level/window trigger block: register
 * indices, mode codes, mask bits, reset values and scaling figures.
 * Assumes the includer applies them to a 32-bit AHB-Lite register file
 * whose byte address is four times the register index.
 */
// How it works
// - Sample inputs every selected sample, evaluate once per sample
// - Each level/window mode yields a gate
// - High mode: gate when above first level
// - High alone: fire entering high, or at start
// - Low mode: gate when below first level
// - Low alone: fire entering low, or at start
// - In-window: gate between lower and upper level
// - In-window alone: fire entering, or at start
// - Outside-window: gate outside the two levels
// - Outside alone: fire on leaving, or at start
// - Two TTL lines, own modes, combinable
// - TTL codes: rising 1, falling 2, both 4
// - TTL codes: high level 8, low 16
// - TTL mode zero excludes the line
// - Read-only supported-mode bitmask per line
// - Line triggers only if OR/AND enabled
// - OR mask bits 4h, 8h enable lines
// - Edge modes: first edge, then wait re-arm
`ifndef ELWT_PARAMS_SVH
`define ELWT_PARAMS_SVH

// Register indices, byte address is index times four
`define ELWT_IDX_OR_MASK 18'h09DDA
`define ELWT_IDX_AND_MASK 18'h09DDB
`define ELWT_IDX_LINE0_AVAIL 18'h09E35
`define ELWT_IDX_LINE1_AVAIL 18'h09E36
`define ELWT_IDX_ANA_MODE 18'h09E3E
`define ELWT_IDX_LINE0_MODE 18'h09E3F
`define ELWT_IDX_LINE1_MODE 18'h09E40
`define ELWT_IDX_STATUS 18'h09E48
`define ELWT_IDX_SAMPLE_DIV 18'h09E49
`define ELWT_IDX_UPPER_LVL 18'h0A550
`define ELWT_IDX_LOWER_LVL 18'h0A55A

// Mode codes shared by analog and TTL mode fields
`define ELWT_MODE_OFF 32'h0000_0000
`define ELWT_MODE_RISE 32'h0000_0001
`define ELWT_MODE_FALL 32'h0000_0002
`define ELWT_MODE_ANY 32'h0000_0004
`define ELWT_MODE_HIGH 32'h0000_0008
`define ELWT_MODE_LOW 32'h0000_0010
`define ELWT_MODE_INWIN 32'h0000_0080
`define ELWT_MODE_OUTWIN 32'h0000_0100

// Mask bits
`define ELWT_MASK_ANALOG 2
`define ELWT_MASK_LINE0 32'h0000_0004
`define ELWT_MASK_LINE_LSB 2

// Reset values
`define ELWT_RST_WORD 32'h0000_0000
`define ELWT_RST_AVAIL 32'h0000_001F

// Threshold scaling, full scale in mV and in sample codes
`define ELWT_FULL_MV 5000
`define ELWT_FULL_CODE 8191

`endif

// >>> inc/elwt_pkg.sv
/*
 * Types for the external level/window trigger block.
 * Assumes elwt_params.svh is available to the design files.
 */
`default_nettype none

package elwt_pkg;

	// Trigger engine state
	typedef enum logic [1:0] {
		ELWT_IDLE = 2'b00,
		ELWT_ARMED = 2'b01,
		ELWT_FIRED = 2'b10
	} elwt_state_e;

	// Software configuration as seen by the detectors
	typedef struct packed {
		logic [31:0] ana_mode;
		logic [31:0] line0_mode;
		logic [31:0] line1_mode;
		logic [31:0] or_mask;
		logic [31:0] and_mask;
		logic signed [31:0] upper_mv;
		logic signed [31:0] lower_mv;
		logic [31:0] sample_div;
	} elwt_cfg_s;

	// Detector results for one sample
	typedef struct packed {
		logic ana_gate;
		logic ana_hit;
		logic [1:0] line_gate;
		logic [1:0] line_hit;
	} elwt_det_s;

endpackage

`default_nettype wire

// >>> sim/elwt_top_asserts.sv
/*
 * Checker on the elwt_top ports: bus handshake and trigger pulses.
 * Assumes one clock and the active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none

module elwt_chk (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	// Bus
	input wire logic hsel_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic hready_in,
	input wire logic [31:0] hrdata_out,
	input wire logic hreadyout_out,
	input wire logic hresp_out,
	// Trigger
	input wire logic start_in,
	input wire logic trigger_out,
	input wire logic armed_out
);
	logic acc;
	logic rdph;

	// Accepted address phase, and its read flavour
	assign acc = hsel_in & htrans_in[1] & hready_in;
	assign rdph = acc & ~hwrite_in;

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!arst_n_in);

	property p_resp;
		hresp_out == 1'b0;
	endproperty
	property p_wait;
		acc |=> !hreadyout_out ##1 hreadyout_out;
	endproperty
	property p_idle;
		!acc |=> hreadyout_out;
	endproperty
	// Read data only moves two edges after a read phase
	property p_hold;
		$changed(hrdata_out) |-> $past(rdph, 2);
	endproperty
	property p_pulse;
		trigger_out |=> !trigger_out;
	endproperty
	property p_armd;
		trigger_out |-> $past(armed_out);
	endproperty
	// Engine arms at the start edge, armed flag registers one edge later
	property p_start;
		$rose(start_in) |-> ##2 armed_out;
	endproperty
	// Only a trigger may end the armed state
	property p_fall;
		$fell(armed_out) |-> trigger_out || $past(trigger_out);
	endproperty

	a_resp: assert property (p_resp) else $error("bus answer not OKAY");
	a_wait: assert property (p_wait) else $error("wait state not one cycle");
	a_idle: assert property (p_idle) else $error("wait state without phase");
	a_hold: assert property (p_hold) else $error("read data moved unasked");
	a_pulse: assert property (p_pulse) else $error("trigger wider than one");
	a_armd: assert property (p_armd) else $error("trigger while not armed");
	a_start: assert property (p_start) else $error("start did not arm");
	a_fall: assert property (p_fall) else $error("disarmed without trigger");

	c_fire: cover property (trigger_out);
	c_read: cover property (rdph);
	c_write: cover property (acc && hwrite_in);
endmodule

bind elwt_top elwt_chk elwt_chk_inst (.sys_clk_in, .arst_n_in, .hsel_in, .htrans_in,
	.hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .start_in,
	.trigger_out, .armed_out);

`default_nettype wire

// >>> sim/elwt_src_model.sv
/*
 * Far-side source: analog sample code and the two TTL lines.
 * Assumes the bench calls put() and both follow the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module elwt_src_model (
	// Clock
	input wire logic clk_in,
	// Trigger inputs of the device
	output logic signed [13:0] smp_out,
	output logic [1:0] ttl_out
);
	// Quiet source at time zero
	initial begin
		smp_out = 14'h0000;
		ttl_out = 2'h0;
	end

	task automatic put(input logic signed [13:0] s, input logic [1:0] t);
		@(posedge clk_in);
		smp_out <= s;
		ttl_out <= t;
	endtask
endmodule

`default_nettype wire

// >>> sim/ext_level_window_trigger_tb_top.sv
/*
 * Bench for elwt_top: registers over the bus, then each trigger mode.
 * Assumes the checker is bound and elwt_src_model drives the inputs.
 */
`timescale 1ns/1ps
`default_nettype none
`include "elwt_params.svh"

`define TB_CHK(a, e) begin \
	total_checks++; \
	if ((a) !== (e)) begin \
		fail_count++; \
		$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); \
	end \
end

module ext_level_window_trigger_tb_top;
	localparam logic [19:0] AD_OR = {`ELWT_IDX_OR_MASK, 2'b00};
	localparam logic [19:0] AD_V0 = {`ELWT_IDX_LINE0_AVAIL, 2'b00};
	localparam logic [19:0] AD_V1 = {`ELWT_IDX_LINE1_AVAIL, 2'b00};
	localparam logic [19:0] AD_AN = {`ELWT_IDX_ANA_MODE, 2'b00};
	localparam logic [19:0] AD_L0 = {`ELWT_IDX_LINE0_MODE, 2'b00};
	localparam logic [19:0] AD_L1 = {`ELWT_IDX_LINE1_MODE, 2'b00};
	localparam logic [19:0] AD_UP = {`ELWT_IDX_UPPER_LVL, 2'b00};
	localparam logic [19:0] AD_LO = {`ELWT_IDX_LOWER_LVL, 2'b00};
	localparam logic [19:0] AD_AM = {`ELWT_IDX_AND_MASK, 2'b00};
	localparam logic [19:0] AD_ST = {`ELWT_IDX_STATUS, 2'b00};
	localparam logic [19:0] AD_DV = {`ELWT_IDX_SAMPLE_DIV, 2'b00};
	logic clk, rst_n, hsel, hwrite, start, hrdy, trig, agate, armed;
	logic [1:0] htrans, ttl, lgate;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic signed [13:0] smp;
	int fail_count, total_checks, tc;

	// Clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	elwt_top elwt_top_inst (.sys_clk_in(clk), .arst_n_in(rst_n), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
		.hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
		.hresp_out(), .ext_sample_in(smp), .ttl_line_in(ttl), .start_in(start),
		.trigger_out(trig), .ana_gate_out(agate), .line_gate_out(lgate), .armed_out(armed));
	elwt_src_model elwt_src_model_inst (.clk_in(clk), .smp_out(smp), .ttl_out(ttl));

	// Trigger pulse count
	always @(posedge clk) begin
		if (trig === 1'b1)
			tc <= tc + 1;
	end

	// One single word transfer; waits on the slave, not a cycle count
	task automatic xf(input logic w, input logic [19:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {12'h000, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		r = hrdata;
	endtask

	task automatic go();
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
	endtask

	// Off value, start, on value, start again; count pulses in each span
	task automatic run(input logic [31:0] m, input logic [19:0] ra, input logic [31:0] md,
		input logic signed [13:0] s0, s1, input logic [1:0] t0, t1, input int e1, e2,
		input logic [2:0] g);
		int c;
		elwt_src_model_inst.put(s0, t0);
		xf(1'b1, AD_OR, m, rv);
		xf(1'b1, AD_AN, 32'h0, rv);
		xf(1'b1, AD_L0, 32'h0, rv);
		xf(1'b1, AD_L1, 32'h0, rv);
		xf(1'b1, ra, md, rv);
		go();
		c = tc;
		repeat (12) @(posedge clk);
		`TB_CHK(tc - c, 0)
		elwt_src_model_inst.put(s1, t1);
		c = tc;
		repeat (12) @(posedge clk);
		`TB_CHK(tc - c, e1)
		`TB_CHK({agate, lgate}, g)
		go();
		c = tc;
		repeat (12) @(posedge clk);
		`TB_CHK(tc - c, e2)
		$display("mode %0h on mask %0h done", md, m);
	endtask

	task automatic conclude();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog, far beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		conclude();
	end

	// Main sequence
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		start = 1'b0;
		rst_n = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		xf(1'b0, AD_V0, 32'h0, rv);
		`TB_CHK(rv, `ELWT_RST_AVAIL)
		xf(1'b0, AD_V1, 32'h0, rv);
		`TB_CHK(rv, `ELWT_RST_AVAIL)
		xf(1'b1, AD_V0, 32'h0, rv);
		xf(1'b0, AD_V0, 32'h0, rv);
		`TB_CHK(rv, `ELWT_RST_AVAIL)
		xf(1'b0, AD_OR, 32'h0, rv);
		`TB_CHK(rv, `ELWT_RST_WORD)
		xf(1'b1, AD_OR, 32'hC, rv);
		xf(1'b0, AD_OR, 32'h0, rv);
		`TB_CHK(rv, 32'h0000_000C)
		xf(1'b0, 20'h00010, 32'h0, rv);
		`TB_CHK(rv, 32'h0)
		xf(1'b1, AD_UP, 32'h0000_03E8, rv);
		xf(1'b1, AD_LO, 32'hFFFF_FC18, rv);
		xf(1'b0, AD_LO, 32'h0, rv);
		`TB_CHK(rv, 32'hFFFF_FC18)
		$display("registers done");
		run(32'h2, AD_AN, `ELWT_MODE_HIGH, 14'h0666, 14'h0667, 2'h0, 2'h0, 1, 1, 3'h4);
		run(32'h2, AD_AN, `ELWT_MODE_LOW, 14'h0666, 14'h0665, 2'h0, 2'h0, 1, 1, 3'h4);
		run(32'h2, AD_AN, `ELWT_MODE_INWIN, 14'h399A, 14'h0, 2'h0, 2'h0, 1, 1, 3'h4);
		run(32'h2, AD_AN, `ELWT_MODE_OUTWIN, 14'h0666, 14'h0667, 2'h0, 2'h0, 1, 1, 3'h4);
		run(32'h4, AD_L0, `ELWT_MODE_RISE, 14'h0, 14'h0, 2'h0, 2'h1, 1, 0, 3'h0);
		run(32'h4, AD_L0, `ELWT_MODE_FALL, 14'h0, 14'h0, 2'h1, 2'h0, 1, 0, 3'h0);
		run(32'h4, AD_L0, `ELWT_MODE_ANY, 14'h0, 14'h0, 2'h0, 2'h1, 1, 0, 3'h0);
		run(32'h4, AD_L0, `ELWT_MODE_HIGH, 14'h0, 14'h0, 2'h0, 2'h1, 1, 1, 3'h1);
		run(32'h4, AD_L0, `ELWT_MODE_LOW, 14'h0, 14'h0, 2'h1, 2'h0, 1, 1, 3'h1);
		run(32'h8, AD_L1, `ELWT_MODE_RISE, 14'h0, 14'h0, 2'h0, 2'h2, 1, 0, 3'h0);
		run(32'h8, AD_L1, `ELWT_MODE_LOW, 14'h0, 14'h0, 2'h2, 2'h0, 1, 1, 3'h2);
		run(32'h4, AD_L0, `ELWT_MODE_OFF, 14'h0, 14'h0, 2'h0, 2'h1, 0, 0, 3'h0);
		run(32'h8, AD_L0, `ELWT_MODE_RISE, 14'h0, 14'h0, 2'h0, 2'h1, 0, 0, 3'h0);
		// AND mask alone must also let a line trigger
		xf(1'b1, AD_AM, 32'h4, rv);
		run(32'h0, AD_L0, `ELWT_MODE_HIGH, 14'h0, 14'h0, 2'h0, 2'h1, 1, 1, 3'h1);
		// Status: line 0 gate high, engine fired, not armed
		xf(1'b0, AD_ST, 32'h0, rv);
		`TB_CHK(rv, 32'h0000_0014)
		xf(1'b1, AD_AM, 32'h0, rv);
		// Slower sample rate, one sample every four clocks
		xf(1'b1, AD_DV, 32'h3, rv);
		run(32'h2, AD_AN, `ELWT_MODE_HIGH, 14'h0666, 14'h0667, 2'h0, 2'h0, 1, 1, 3'h4);
		xf(1'b1, AD_DV, 32'h0, rv);
		conclude();
	end
endmodule

`default_nettype wire
